// File: rtl/tmr_pkg.sv
package tmr_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TX = 8'h04;
  localparam logic [7:0] OFS_XMODE = 8'h08;
  localparam logic [7:0] OFS_TY = 8'h0c;
  localparam logic [7:0] OFS_TZ = 8'h10;
  localparam logic [7:0] OFS_TC = 8'h18;
  localparam logic [7:0] OFS_CAP = 8'h1c;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam logic [7:0] OFS_MASK = 8'h24;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTL_XS = 0;
  localparam int CTL_YS = 1;
  localparam int CTL_ZS = 2;
  localparam int CTL_CS = 3;
  localparam int CTL_ZM = 4;
  localparam int XM_PP = 0;
  localparam int XM_EDGE = 1;
  localparam int XM_UND = 2;
  localparam int XM_POL = 3;
  localparam int ST_XUF = 0;
  localparam int ST_XEDGE = 1;
  localparam int ST_YUF = 2;
  localparam int ST_ZUF = 3;
  localparam int ST_CCAP = 4;
  localparam int NUM_EV = 5;
  // ****************************************
  // reset values and encodings
  // ****************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] XMODE_RST = 4'h0;
  localparam logic [NUM_EV-1:0] MASK_RST = 5'h00;
  localparam logic [1:0] ZM_TIMER = 2'h0;
  localparam logic [1:0] ZM_ONESHOT = 2'h1;
  localparam logic [1:0] ZM_WAITONE = 2'h2;
  localparam logic [2:0] SZ_BYTE = 3'h0;
  typedef enum logic [1:0] {BUS_IDLE, BUS_RD1, BUS_RD2} bus_e;
endpackage

// File: rtl/timer_group.sv
`timescale 1ns/1ps
// Functional notes
// - timers X, Y and Z stay stopped after reset until software loads and starts them.
// - a prescaler-plus-counter read is taken as two byte samples, so the count may move.
// - in pulse period mode writing 0 to the edge or underflow flag clears it.
// - writing 1 to either timer X flag leaves it unchanged; only events set them.
// - on entry to pulse period mode the flags are undefined and software zeroes both.
// - in the timer Z one-shot modes clearing the start bit reloads the counter and stops.
// - a 16-bit timer C read returns a coherent high and low byte pair.

// ****************************************
// prescaler followed by an 8-bit counter
// ****************************************
module presc_counter #(
  parameter int W = 8
) (
  input wire logic clk, // clock
  input wire logic rstn, // sync reset, low
  input wire logic ce, // clock enable
  input wire logic run, // counting allowed
  input wire logic load, // software write
  input wire logic [W-1:0] pre_val, // prescaler value
  input wire logic [W-1:0] cnt_val, // counter value
  input wire logic restore, // reload and hold
  output logic [W-1:0] pre, // live prescaler
  output logic [W-1:0] cnt, // live counter
  output logic uf // underflow pulse
);
  logic [W-1:0] pre_rl;
  logic [W-1:0] cnt_rl;
  wire pre_zero = (pre == '0);
  wire cnt_zero = (cnt == '0);

  // down count, reload on underflow
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre <= '0;
      cnt <= '0;
      pre_rl <= '0;
      cnt_rl <= '0;
      uf <= 1'b0;
    end else if (ce) begin
      uf <= 1'b0;
      if (load) begin
        pre <= pre_val;
        cnt <= cnt_val;
        pre_rl <= pre_val;
        cnt_rl <= cnt_val;
      end else if (restore) begin
        pre <= pre_rl;
        cnt <= cnt_rl;
      end else if (run) begin
        if (pre_zero) begin
          pre <= pre_rl;
          if (cnt_zero) begin
            cnt <= cnt_rl;
            uf <= 1'b1;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end else begin
          pre <= pre - 1'b1;
        end
      end
    end
  end
endmodule

// ****************************************
// timer group top
// ****************************************
module timer_group
  import tmr_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic CLK, // system clock
  input wire logic RSTN, // sync reset, low
  input wire logic CE, // clock enable
  input wire logic HSEL, // slave select
  input wire logic [31:0] HADDR, // address
  input wire logic [1:0] HTRANS, // transfer type
  input wire logic HWRITE, // write
  input wire logic [2:0] HSIZE, // size
  input wire logic [31:0] HWDATA, // write data
  input wire logic HREADY, // bus ready
  output logic [31:0] HRDATA, // read data
  output logic HREADYOUT, // slave ready
  output logic HRESP, // always okay
  input wire logic X_IN, // timer X pulse pin
  input wire logic C_IN, // timer C capture pin
  output logic Z_OUT, // timer Z one-shot out
  output logic IRQ // interrupt level
);
  // ****************************************
  // state
  // ****************************************
  bus_e bus;
  logic [7:0] ctrl;
  logic [3:0] xmode;
  logic [NUM_EV-1:0] stat;
  logic [NUM_EV-1:0] mask;
  logic [CW-1:0] tcnt;
  logic [CW-1:0] tcap;
  logic [7:0] c_hi_latch;
  logic [7:0] a_addr;
  logic [2:0] a_size;
  logic wr_pend;
  logic [7:0] rd_lo;
  logic [31:0] snap;
  logic [2:0] x_sync;
  logic [2:0] c_sync;

  // ****************************************
  // bus decode
  // ****************************************
  wire addr_ok = HSEL && HTRANS[1] && HREADY;
  wire [1:0] bl = a_addr[1:0];
  wire [3:0] be_byte = 4'h1 << bl;
  wire [3:0] be_half = bl[1] ? 4'hc : 4'h3;
  wire [3:0] be = (a_size == SZ_BYTE) ? be_byte : (a_size == 3'h1) ? be_half : 4'hf;
  wire [7:0] wa = {a_addr[7:2], 2'b00};
  wire wr_ctrl = wr_pend && (wa == OFS_CTRL) && be[0];
  wire wr_x = wr_pend && (wa == OFS_TX);
  wire wr_xm = wr_pend && (wa == OFS_XMODE) && be[0];
  wire wr_y = wr_pend && (wa == OFS_TY);
  wire wr_z = wr_pend && (wa == OFS_TZ);
  wire wr_tc = wr_pend && (wa == OFS_TC);
  wire wr_mask = wr_pend && (wa == OFS_MASK) && be[0];
  wire rd_end = (bus == BUS_RD2);
  wire rd_stat = rd_end && (wa == OFS_STAT);
  wire c_lo_byte = (a_size == SZ_BYTE) && (bl == 2'h0);
  wire c_hi_byte = (a_size == SZ_BYTE) && (bl == 2'h1);

  // ****************************************
  // pin synchronisers and edges
  // ****************************************
  // stage 0 feeds stage 1 only; edges look at stages 1 and 2
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      x_sync <= 3'h0;
      c_sync <= 3'h0;
    end else if (CE) begin
      x_sync <= {x_sync[1:0], X_IN};
      c_sync <= {c_sync[1:0], C_IN};
    end
  end

  wire x_rise = x_sync[1] && !x_sync[2];
  wire x_fall = !x_sync[1] && x_sync[2];
  wire x_edge_ev = xmode[XM_PP] && ctrl[CTL_XS] && (xmode[XM_POL] ? x_fall : x_rise);
  wire c_cap_ev = ctrl[CTL_CS] && c_sync[1] && !c_sync[2];

  // ****************************************
  // timers X, Y and Z
  // ****************************************
  wire [1:0] zmode = ctrl[CTL_ZM+1:CTL_ZM];
  wire z_oneshot = (zmode == ZM_ONESHOT) || (zmode == ZM_WAITONE);
  // start bit falling by software write in a one-shot mode
  wire z_stop_sw = wr_ctrl && z_oneshot && ctrl[CTL_ZS] && !HWDATA[CTL_ZS];
  wire [7:0] x_pre;
  wire [7:0] x_cnt;
  wire [7:0] y_pre;
  wire [7:0] y_cnt;
  wire [7:0] z_pre;
  wire [7:0] z_cnt;
  wire x_uf;
  wire y_uf;
  wire z_uf;

  // run only on the start bits, all clear after reset
  presc_counter #(.W(8)) u_tx (
    .clk(CLK), .rstn(RSTN), .ce(CE),
    .run(ctrl[CTL_XS]),
    .load(wr_x && be[0] && be[1]),
    .pre_val(HWDATA[7:0]), .cnt_val(HWDATA[15:8]), .restore(1'b0),
    .pre(x_pre), .cnt(x_cnt), .uf(x_uf)
  );
  presc_counter #(.W(8)) u_ty (
    .clk(CLK), .rstn(RSTN), .ce(CE),
    .run(ctrl[CTL_YS]),
    .load(wr_y && be[0] && be[1]),
    .pre_val(HWDATA[7:0]), .cnt_val(HWDATA[15:8]), .restore(1'b0),
    .pre(y_pre), .cnt(y_cnt), .uf(y_uf)
  );
  // one-shot end also reloads from the reload values
  presc_counter #(.W(8)) u_tz (
    .clk(CLK), .rstn(RSTN), .ce(CE),
    .run(ctrl[CTL_ZS]),
    .load(wr_z && be[0] && be[1]),
    .pre_val(HWDATA[7:0]), .cnt_val(HWDATA[15:8]),
    .restore(z_stop_sw),
    .pre(z_pre), .cnt(z_cnt), .uf(z_uf)
  );

  // ****************************************
  // control register
  // ****************************************
  // hardware ends a one-shot on underflow; that stop wins over a write
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctrl <= CTRL_RST;
    end else if (CE) begin
      if (wr_ctrl) begin
        ctrl <= HWDATA[7:0];
      end
      if (z_uf && z_oneshot) begin
        ctrl[CTL_ZS] <= 1'b0;
      end
    end
  end

  // ****************************************
  // timer X mode register and flags
  // ****************************************
  // a written 0 clears, a written 1 keeps; an event in the same cycle wins
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      xmode <= XMODE_RST;
    end else if (CE) begin
      if (wr_xm) begin
        xmode[XM_PP] <= HWDATA[XM_PP];
        xmode[XM_POL] <= HWDATA[XM_POL];
        xmode[XM_EDGE] <= (xmode[XM_EDGE] && HWDATA[XM_EDGE]) || x_edge_ev;
        xmode[XM_UND] <= (xmode[XM_UND] && HWDATA[XM_UND]) || (xmode[XM_PP] && x_uf);
      end else begin
        xmode[XM_EDGE] <= xmode[XM_EDGE] || x_edge_ev;
        xmode[XM_UND] <= xmode[XM_UND] || (xmode[XM_PP] && x_uf);
      end
    end
  end

  // ****************************************
  // timer C counter and capture
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      tcnt <= '0;
      tcap <= '0;
    end else if (CE) begin
      if (wr_tc && be[0] && be[1]) begin
        tcnt <= HWDATA[CW-1:0];
      end else if (ctrl[CTL_CS]) begin
        tcnt <= tcnt + 1'b1;
      end
      if (c_cap_ev) begin
        tcap <= tcnt;
      end
    end
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  wire [NUM_EV-1:0] ev = {c_cap_ev, z_uf, y_uf, x_edge_ev, x_uf};

  // read clears; an event in the clearing cycle stays set
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      stat <= '0;
      mask <= MASK_RST;
      IRQ <= 1'b0;
      Z_OUT <= 1'b0;
    end else if (CE) begin
      stat <= (rd_stat ? '0 : stat) | ev;
      if (wr_mask) begin
        mask <= HWDATA[NUM_EV-1:0];
      end
      IRQ <= |(stat & mask);
      Z_OUT <= ctrl[CTL_ZS] && z_oneshot;
    end
  end

  // ****************************************
  // read data selection
  // ****************************************
  // whole-word view used when the word is taken in one sample
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0;
    case (wa)
      OFS_CTRL: rd_word = {24'h0, ctrl};
      OFS_XMODE: rd_word = {28'h0, xmode};
      OFS_TC: rd_word = {{(32-CW){1'b0}}, tcnt};
      OFS_CAP: rd_word = {{(32-CW){1'b0}}, tcap};
      OFS_STAT: rd_word = {{(32-NUM_EV){1'b0}}, stat};
      OFS_MASK: rd_word = {{(32-NUM_EV){1'b0}}, mask};
      default: rd_word = 32'h0;
    endcase
  end

  wire is_pc = (wa == OFS_TX) || (wa == OFS_TY) || (wa == OFS_TZ);
  wire [7:0] pre_sel = (wa == OFS_TX) ? x_pre : (wa == OFS_TY) ? y_pre : z_pre;
  wire [7:0] cnt_sel = (wa == OFS_TX) ? x_cnt : (wa == OFS_TY) ? y_cnt : z_cnt;
  wire is_c = (wa == OFS_TC) || (wa == OFS_CAP);
  // byte reads of timer C: low byte latches high byte, high byte returns it
  wire [31:0] c_word = c_hi_byte ? {16'h0, c_hi_latch, 8'h0} : snap;
  // second byte is sampled a cycle after the first, live count
  wire [31:0] pc_word = {16'h0, cnt_sel, rd_lo};
  wire [31:0] rd_final = is_pc ? pc_word : is_c ? c_word : snap;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // reads take two wait states so the byte pair is sampled in two steps
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      bus <= BUS_IDLE;
      HREADYOUT <= 1'b1;
      HRDATA <= 32'h0;
      HRESP <= 1'b0;
      a_addr <= 8'h0;
      a_size <= 3'h0;
      wr_pend <= 1'b0;
      rd_lo <= 8'h0;
      snap <= 32'h0;
      c_hi_latch <= 8'h0;
    end else if (CE) begin
      wr_pend <= 1'b0;
      unique case (bus)
        BUS_IDLE: begin
          if (addr_ok) begin
            a_addr <= HADDR[7:0];
            a_size <= HSIZE;
            if (HWRITE) begin
              wr_pend <= 1'b1;
            end else begin
              bus <= BUS_RD1;
              HREADYOUT <= 1'b0;
            end
          end
        end
        BUS_RD1: begin
          rd_lo <= pre_sel;
          snap <= rd_word;
          if (is_c && c_lo_byte) begin
            c_hi_latch <= rd_word[15:8];
          end
          bus <= BUS_RD2;
        end
        BUS_RD2: begin
          HRDATA <= rd_final;
          HREADYOUT <= 1'b1;
          bus <= BUS_IDLE;
        end
        // the spare code falls back to idle so the bus can never lock up
        default: begin
          bus <= BUS_IDLE;
          HREADYOUT <= 1'b1;
        end
      endcase
    end
  end

endmodule

// File: test/timer_group_monitor.sv
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module timer_group_monitor
  import tmr_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic CLK, // clock
  input wire logic RSTN, // reset, low
  input wire logic CE, // enable
  input wire logic HSEL, // select
  input wire logic [31:0] HADDR, // address
  input wire logic [1:0] HTRANS, // type
  input wire logic HWRITE, // write
  input wire logic [2:0] HSIZE, // size
  input wire logic [31:0] HWDATA, // wdata
  input wire logic HREADY, // ready in
  input wire logic [31:0] HRDATA, // rdata
  input wire logic HREADYOUT, // ready out
  input wire logic HRESP, // response
  input wire logic X_IN, // x pin
  input wire logic C_IN, // c pin
  input wire logic Z_OUT, // z out
  input wire logic IRQ // interrupt
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic wr_ph;
  logic [7:0] wr_ofs;
  logic [NUM_EV-1:0] mask_q;
  logic zs_q;
  wire take = CE && HSEL && HTRANS[1] && HREADY;
  wire ctrl_wr = wr_ph && wr_ofs == OFS_CTRL;
  // shadow of the write data phase, mask and z start bit
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      wr_ph <= 1'b0;
      wr_ofs <= 8'h00;
      mask_q <= MASK_RST;
      zs_q <= 1'b0;
    end else if (CE) begin
      if (HREADY) begin
        wr_ph <= take && HWRITE;
        wr_ofs <= HADDR[7:0];
      end
      if (wr_ph && wr_ofs == OFS_MASK) mask_q <= HWDATA[NUM_EV-1:0];
      if (ctrl_wr) zs_q <= HWDATA[CTL_ZS];
    end
  end
  sequence rd_take;
    take && !HWRITE;
  endsequence
  sequence z_stop;
    ctrl_wr && !HWDATA[CTL_ZS] && Z_OUT;
  endsequence
  AST_RD_WAIT: assert property (rd_take |=> !HREADYOUT [*2] ##1 HREADYOUT)
    else $error("read wait is not two cycles");
  AST_WR_NOWAIT: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write was stalled");
  AST_OKAY: assert property (HRESP == 1'b0)
    else $error("response not okay");
  AST_RD_HOLD: assert property (!$rose(HREADYOUT) |-> $stable(HRDATA))
    else $error("read data moved outside a read");
  AST_UNMAPPED: assert property (take && !HWRITE && HADDR[7:2] > OFS_MASK[7:2]
    |-> ##3 HRDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_IRQ_MASKED: assert property (mask_q == 0 && $past(mask_q) == 0 |-> !IRQ)
    else $error("interrupt with all masked");
  AST_RESET_IDLE: assert property ($rose(RSTN) |-> !IRQ && !Z_OUT && HREADYOUT)
    else $error("outputs not idle after reset");
  AST_Z_START: assert property ($rose(Z_OUT) |-> zs_q)
    else $error("timer z ran without start");
  AST_Z_STOP: assert property (z_stop |-> ##[1:2] !Z_OUT)
    else $error("timer z kept running after stop");
endmodule

bind timer_group timer_group_monitor #(.CW(CW)) u_timer_group_monitor (
  .CLK(CLK), .RSTN(RSTN), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .X_IN(X_IN), .C_IN(C_IN), .Z_OUT(Z_OUT), .IRQ(IRQ));

// File: test/tb.sv
`timescale 1ns/1ps
module tb
  import tmr_pkg::*;
;
  logic clk, rstn, ce, hsel, hwrite, x_in, c_in, hreadyout, hresp, z_out, irq;
  logic [31:0] haddr, hwdata, hrdata, v, w, h, cap;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int err_total, checked;
  logic [7:0] offs [9] = '{OFS_CTRL, OFS_TX, OFS_XMODE, OFS_TY, OFS_TZ, OFS_TC, OFS_CAP,
    OFS_STAT, OFS_MASK};
  logic [1:0] zm [2] = '{ZM_ONESHOT, ZM_WAITONE};
  // clock enable driven by the bench; one scenario freezes timer c
  timer_group #(.CW(16)) u_timer_group (.CLK(clk), .RSTN(rstn), .CE(ce), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .X_IN(x_in), .C_IN(c_in), .Z_OUT(z_out), .IRQ(irq));
  always #2.5 clk = ~clk;
  // ****************************************
  // bus tasks
  // ****************************************
  // one single transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [2:0] sz,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= sz;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, 3'h2, d, v);
  endtask
  task automatic rd32(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 3'h2, 32'h0, d);
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    rd32(a, v);
    check(what, v, exp);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  // main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {hsel, hwrite, x_in, c_in, htrans, hsize, haddr, hwdata} = '0;
    ce = 1'b1;
    err_total = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (offs[i]) rd_chk(offs[i], 32'h0, "reset value");
    check("idle outputs", {29'h0, irq, z_out, hresp}, 32'h0);
    wr32(OFS_TX, 32'h100);
    repeat (8) @(posedge clk);
    rd_chk(OFS_TX, 32'h100, "x loaded not started");
    // pulse period flags: set by events only, cleared by zero
    wr32(OFS_XMODE, 32'h1);
    rd_chk(OFS_XMODE, 32'h1, "x mode entry");
    wr32(OFS_CTRL, 32'h1);
    repeat (6) @(posedge clk);
    x_in <= 1'b1;
    repeat (8) @(posedge clk);
    wr32(OFS_CTRL, 32'h0);
    rd_chk(OFS_XMODE, 32'h7, "x flags set by events");
    wr32(OFS_XMODE, 32'h7);
    rd_chk(OFS_XMODE, 32'h7, "x flags write one");
    wr32(OFS_XMODE, 32'h5);
    rd_chk(OFS_XMODE, 32'h5, "x edge flag cleared");
    wr32(OFS_XMODE, 32'h3);
    rd_chk(OFS_XMODE, 32'h1, "x underflow flag cleared");
    // falling polarity, then both flags zeroed in one write
    wr32(OFS_XMODE, 32'h9);
    wr32(OFS_CTRL, 32'h1);
    x_in <= 1'b0;
    repeat (8) @(posedge clk);
    wr32(OFS_CTRL, 32'h0);
    rd_chk(OFS_XMODE, 32'hf, "x falling edge flag");
    wr32(OFS_XMODE, 32'h1);
    rd_chk(OFS_XMODE, 32'h1, "x flags zeroed");
    // interrupt masked, unmasked, cleared by status read
    check("irq masked", {31'h0, irq}, 32'h0);
    wr32(OFS_MASK, 32'h3);
    repeat (2) @(posedge clk);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    rd_chk(OFS_STAT, 32'h3, "status events");
    repeat (2) @(posedge clk);
    check("irq after clear", {31'h0, irq}, 32'h0);
    rd_chk(OFS_STAT, 32'h0, "status read clears");
    rd_chk(OFS_MASK, 32'h3, "mask");
    wr32(8'h30, 32'hffffffff);
    rd_chk(8'h30, 32'h0, "unmapped");
    // timer z in both one-shot modes: stop reloads the count
    foreach (zm[i]) begin
      wr32(OFS_TZ, 32'hffff);
      wr32(OFS_CTRL, {26'h0, zm[i], 4'h4});
      repeat (2) @(posedge clk);
      check("z out running", {31'h0, z_out}, 32'h1);
      rd32(OFS_TZ, w);
      check("z live count", {31'h0, w !== 32'hffff}, 32'h1);
      wr32(OFS_CTRL, {26'h0, zm[i], 4'h0});
      repeat (2) @(posedge clk);
      check("z out stopped", {31'h0, z_out}, 32'h0);
      rd_chk(OFS_TZ, 32'hffff, "z reload on stop");
    end
    // timer y free run; timer z one-shot ends itself on underflow
    wr32(OFS_TY, 32'h100);
    wr32(OFS_TZ, 32'h101);
    wr32(OFS_CTRL, 32'h16);
    repeat (10) @(posedge clk);
    check("z out after one-shot", {31'h0, z_out}, 32'h0);
    check("irq events masked", {31'h0, irq}, 32'h0);
    rd_chk(OFS_CTRL, 32'h12, "z start cleared at end");
    wr32(OFS_CTRL, 32'h0);
    rd_chk(OFS_STAT, 32'hc, "y and z underflow");
    // timer c: capture, then byte pair against word and halfword snapshot
    wr32(OFS_CTRL, 32'h8);
    repeat (10) @(posedge clk);
    c_in <= 1'b1;
    repeat (10) @(posedge clk);
    wr32(OFS_CTRL, 32'h0);
    rd32(OFS_TC, w);
    rd32(OFS_CAP, cap);
    xfer(1'b0, OFS_TC, SZ_BYTE, 32'h0, v);
    xfer(1'b0, OFS_TC + 8'h1, SZ_BYTE, 32'h0, h);
    check("c byte pair", {16'h0, h[15:8], v[7:0]}, w);
    xfer(1'b0, OFS_TC, 3'h1, 32'h0, v);
    check("c halfword", v, w);
    check("c capture", {31'h0, cap !== 32'h0 && cap !== w}, 32'h1);
    rd_chk(OFS_STAT, 32'h10, "capture event");
    // enable low freezes timer c: three ticks after one snapshot, one before the next
    wr32(OFS_CTRL, 32'h8);
    rd32(OFS_TC, w);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    rd32(OFS_TC, v);
    check("c frozen by enable", v - w, 32'h4);
    // second reset with timer z running
    wr32(OFS_CTRL, 32'h14);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check("z after reset", {31'h0, z_out}, 32'h0);
    rd_chk(OFS_CTRL, 32'h0, "ctrl after reset");
    print_verdict();
  end
endmodule
